/* File: cps_map.vh */
`ifndef CPS_MAP_VH
`define CPS_MAP_VH
// register byte offsets
`define CPS_ADR_PSW 4'h0
`define CPS_ADR_RES 4'h4
`define CPS_ADR_FLG 4'h8
`define CPS_ADR_IRQ 4'hc
// field positions
`define CPS_TRC_HI 15
`define CPS_TRC_LO 14
`define CPS_PRV_BIT 13
`define CPS_IML_HI 10
`define CPS_IML_LO 8
`define CPS_FX_BIT 4
`define CPS_FN_BIT 3
`define CPS_FZ_BIT 2
`define CPS_FV_BIT 1
`define CPS_FC_BIT 0
// writable bits of the word
`define CPS_PSW_MASK 16'he71f
// reset values (flags undefined, taken as zero)
`define CPS_PSW_RST 16'h2700
// trace modes
`define CPS_TRC_OFF 2'h0
`define CPS_TRC_FLOW 2'h1
`define CPS_TRC_INSN 2'h2
// operation codes
`define CPS_OP_NONE 3'h0
`define CPS_OP_ADD 3'h1
`define CPS_OP_SUB 3'h2
`define CPS_OP_LSL 3'h3
`define CPS_OP_LSR 3'h4
`define CPS_OP_ROXL 3'h5
`define CPS_OP_ROXR 3'h6
`define CPS_OP_LOGIC 3'h7
`endif

/* File: cps_status_word.v */
`timescale 1ns/100ps
`include "cps_map.vh"
// How it works
// RULE_01: 16-bit word: trace 15:14, privilege 13, mask 10:8, flags 4:0.
// RULE_02: supervisor reaches whole word; user reaches only the low flag byte.
// RULE_03: trace mode 00 off, 01 flow change, 10 each instruction, 11 reserved.
// RULE_04: privilege bit 0 means user, 1 means supervisor.
// RULE_05: interrupt mask level 0..7 masks requests at or below it; the code never masks request level 7.
// RULE_06: multiprecision bit written with the same value as carry.
// RULE_07: sign flag follows result most significant bit.
// RULE_08: zero flag set when whole result is zero.
// RULE_09: overflow flag set on two's complement overflow.
// RULE_10: carry set on carry or borrow; shifts and rotates chain through it; the code rotates in the multiprecision bit, shifts fill with zero.
// RULE_11: unassigned bits 12, 11, 7, 6, 5 read zero, writes ignored.
module cps_status_word (
    input wire clk_sys_i, // 20 MHz clock
    input wire sys_rst_i, // sync reset, high
    input wire [3:0] wb_adr_i, // byte address
    input wire [31:0] wb_dat_i, // write data
    output reg [31:0] wb_dat_o, // read data
    input wire [3:0] wb_sel_i, // byte lanes
    input wire wb_we_i, // write
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    output reg wb_ack_o, // acknowledge
    output reg wb_err_o, // unmapped address
    input wire [2:0] irq_level_i, // pending request level
    input wire insn_done_i, // instruction retired pulse
    input wire flow_change_i, // branch taken pulse
    output wire [15:0] psw_o, // status word
    output wire supervisor_o, // supervisor privilege
    output wire irq_take_o, // request beats mask
    output wire trace_req_o // trace exception request
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [15:0] psw_q;
reg [31:0] res_q;
reg [2:0] op_q;
reg [31:0] opa_q;
reg [31:0] opb_q;
reg [31:0] alu_res;
reg alu_c;
reg alu_v;
reg alu_upd;
reg alu_x_upd;
reg [32:0] sum;

// ----------------------------------------
// bus decode
// ----------------------------------------
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
// writes land at the edge where the master sees ack
wire commit = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
wire hit_psw = (wb_adr_i == `CPS_ADR_PSW);
wire hit_res = (wb_adr_i == `CPS_ADR_RES);
wire hit_a = (wb_adr_i == `CPS_ADR_FLG);
wire hit_b = (wb_adr_i == `CPS_ADR_IRQ);
wire hit = hit_psw | hit_res | hit_a | hit_b;
wire sup = psw_q[`CPS_PRV_BIT]; // [RULE_04]

function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer k;
    begin
        lane_merge = old_v;
        for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
                lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
            end
        end
    end
endfunction

// ----------------------------------------
// flag arithmetic
// ----------------------------------------
always @* begin
    alu_res = 32'h0;
    alu_c = 1'b0;
    alu_v = 1'b0;
    alu_upd = 1'b1;
    alu_x_upd = 1'b1;
    sum = 33'h0;
    case (op_q)
        `CPS_OP_ADD: begin
            sum = {1'b0, opa_q} + {1'b0, opb_q};
            alu_res = sum[31:0];
            alu_c = sum[32]; // [RULE_10]
            alu_v = (opa_q[31] == opb_q[31]) &
                (alu_res[31] != opa_q[31]); // [RULE_09]
        end
        `CPS_OP_SUB: begin
            sum = {1'b0, opa_q} - {1'b0, opb_q};
            alu_res = sum[31:0];
            alu_c = sum[32]; // borrow [RULE_10]
            alu_v = (opa_q[31] != opb_q[31]) &
                (alu_res[31] != opa_q[31]); // [RULE_09]
        end
        `CPS_OP_LSL: begin
            alu_res = {opa_q[30:0], 1'b0};
            alu_c = opa_q[31];
            alu_v = opa_q[31] ^ opa_q[30];
        end
        `CPS_OP_LSR: begin
            alu_res = {1'b0, opa_q[31:1]};
            alu_c = opa_q[0];
        end
        `CPS_OP_ROXL: begin
            alu_res = {opa_q[30:0], psw_q[`CPS_FX_BIT]}; // [RULE_10]
            alu_c = opa_q[31];
        end
        `CPS_OP_ROXR: begin
            alu_res = {psw_q[`CPS_FX_BIT], opa_q[31:1]}; // [RULE_10]
            alu_c = opa_q[0];
        end
        `CPS_OP_LOGIC: begin
            alu_res = opa_q & opb_q;
            alu_x_upd = 1'b0; // logic leaves multiprecision bit
        end
        default: begin
            alu_upd = 1'b0;
            alu_x_upd = 1'b0;
        end
    endcase
end

// ----------------------------------------
// register file and bus answer
// ----------------------------------------
wire [31:0] wmask = sup ? {16'h0, `CPS_PSW_MASK} :
    {24'h0, 8'h1f}; // [RULE_02] [RULE_11]
wire [31:0] wnew = lane_merge({16'h0, psw_q}, wb_dat_i, wb_sel_i);

always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
        psw_q <= `CPS_PSW_RST;
        res_q <= 32'h0;
        op_q <= `CPS_OP_NONE;
        opa_q <= 32'h0;
        opb_q <= 32'h0;
        wb_ack_o <= 1'b0;
        wb_err_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end else begin
        wb_ack_o <= req & hit;
        wb_err_o <= req & ~hit;
        op_q <= `CPS_OP_NONE;
        if (alu_upd) begin
            res_q <= alu_res;
            psw_q[`CPS_FN_BIT] <= alu_res[31]; // [RULE_07]
            psw_q[`CPS_FZ_BIT] <= (alu_res == 32'h0); // [RULE_08]
            psw_q[`CPS_FV_BIT] <= alu_v; // [RULE_09]
            psw_q[`CPS_FC_BIT] <= alu_c; // [RULE_10]
            if (alu_x_upd) begin
                psw_q[`CPS_FX_BIT] <= alu_c; // [RULE_06]
            end
        end
        if (commit) begin
            if (hit_psw) begin
                psw_q <= ((psw_q & ~wmask[15:0]) |
                    (wnew[15:0] & wmask[15:0])); // [RULE_02] [RULE_11]
            end
            if (hit_a) begin
                opa_q <= lane_merge(opa_q, wb_dat_i, wb_sel_i);
            end
            if (hit_b) begin
                opb_q <= lane_merge(opb_q, wb_dat_i, wb_sel_i);
            end
            if (hit_res) begin
                op_q <= wb_dat_i[2:0];
            end
        end
        if (req & hit & ~wb_we_i) begin
            if (hit_psw) begin
                wb_dat_o <= sup ? {16'h0, psw_q} :
                    {24'h0, psw_q[7:0]}; // [RULE_02]
            end else if (hit_res) begin
                wb_dat_o <= res_q;
            end else if (hit_a) begin
                wb_dat_o <= opa_q;
            end else begin
                wb_dat_o <= opb_q;
            end
        end
    end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign psw_o = psw_q; // [RULE_01]
assign supervisor_o = sup; // [RULE_04]
assign irq_take_o = (irq_level_i == 3'h7) |
    (irq_level_i > psw_q[`CPS_IML_HI:`CPS_IML_LO]); // [RULE_05]
assign trace_req_o =
    ((psw_q[`CPS_TRC_HI:`CPS_TRC_LO] == `CPS_TRC_FLOW) & flow_change_i) |
    ((psw_q[`CPS_TRC_HI:`CPS_TRC_LO] == `CPS_TRC_INSN) & insn_done_i);
    // [RULE_03]

endmodule // cps_status_word

/* File: cps_status_word_properties.sv */
`timescale 1ns/100ps
module cps_status_word_chk (
    input wire clk_sys_i, // clock
    input wire sys_rst_i, // reset
    input wire [3:0] wb_adr_i, // address
    input wire [31:0] wb_dat_i, // write data
    input wire [3:0] wb_sel_i, // lanes
    input wire wb_we_i, // write
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_ack_o, // ack
    input wire wb_err_o, // error
    input wire [2:0] irq_level_i, // level
    input wire insn_done_i, // retired
    input wire flow_change_i, // branch
    input wire [15:0] psw_o, // word
    input wire supervisor_o, // privilege
    input wire irq_take_o, // take
    input wire trace_req_o // trace
);
    // ----------
    // properties
    // ----------
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire psw_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i &
        (wb_adr_i == 4'h0);
    sequence s_answer;
        (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o;
    endsequence
    property p_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    a_one_answer: assert property (take |=> s_answer)
        else $error("bus answer missing");
    a_ack_pulse: assert property (p_pulse)
        else $error("ack longer than one cycle");
    a_spare_zero: assert property ((psw_o & 16'h18e0) == 16'h0)
        else $error("spare bits set");
    a_priv_bit: assert property (supervisor_o == psw_o[13])
        else $error("privilege out of step");
    a_mask_level: assert property (irq_take_o == (irq_level_i == 3'h7 ||
        irq_level_i > psw_o[10:8]))
        else $error("mask decision wrong");
    a_trace_mode: assert property (trace_req_o == (psw_o[15:14] == 2'h1 &&
        flow_change_i || psw_o[15:14] == 2'h2 && insn_done_i))
        else $error("trace request wrong");
    a_user_guard: assert property (psw_wr & ~psw_o[13] |=>
        $stable(psw_o[15:5]))
        else $error("user write reached system byte");
    a_sup_write: assert property (psw_wr & psw_o[13] & &wb_sel_i[1:0] |=>
        psw_o == ($past(wb_dat_i[15:0]) & 16'he71f))
        else $error("supervisor write not stored");
endmodule // cps_status_word_chk
bind cps_status_word cps_status_word_chk cps_status_word_chk_i (.*);

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    reg clk_sys_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [3:0] wb_adr_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg [3:0] wb_sel_i = 4'hf;
    reg wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    reg [2:0] irq_level_i = 3'h0;
    reg insn_done_i = 1'b0, flow_change_i = 1'b0, er;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, wb_err_o, supervisor_o, irq_take_o, trace_req_o;
    wire [15:0] psw_o;
    integer miscompares = 0, samples_checked = 0, cycles = 0, i, j;
    reg [31:0] rd;
    cps_status_word cps_status_word_i (.*);
    // -----------
    // bus, checks
    // -----------
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    task give_verdict;
        begin
            $display("checked %0d mismatched %0d", samples_checked,
                miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            samples_checked = samples_checked + 1;
            if (s !== e) begin
                miscompares = miscompares + 1;
                $display("Error %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task bus(input [3:0] a, input w, input [31:0] d);
        begin
            @(posedge clk_sys_i);
            wb_adr_i <= a;
            wb_we_i <= w;
            wb_dat_i <= d;
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            @(posedge clk_sys_i);
            while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
                @(posedge clk_sys_i);
            rd = wb_dat_o;
            er = wb_err_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    task op(input [31:0] a, input [31:0] b, input [2:0] c, input [7:0] e);
        begin
            bus(4'h8, 1'b1, a);
            bus(4'hc, 1'b1, b);
            bus(4'h4, 1'b1, {29'h0, c});
            bus(4'h0, 1'b0, 32'h0);
            chk("flags", {24'h0, e}, {24'h0, rd[7:0]});
        end
    endtask
    task t_ctrl;
        for (i = 0; i < 8; i = i + 1) begin
            bus(4'h0, 1'b1, {16'h0, i[1:0], 3'h4, i[2:0], 8'hff});
            bus(4'h0, 1'b0, 32'h0);
            chk("psw", {16'h0, i[1:0], 3'h4, i[2:0], 8'h1f}, rd);
            @(posedge clk_sys_i);
            insn_done_i <= 1'b1;
            @(negedge clk_sys_i);
            chk("trace", i[1:0] == 2'h2, trace_req_o);
            @(posedge clk_sys_i);
            insn_done_i <= 1'b0;
            flow_change_i <= 1'b1;
            @(negedge clk_sys_i);
            chk("trace", i[1:0] == 2'h1, trace_req_o);
            @(posedge clk_sys_i);
            flow_change_i <= 1'b0;
            for (j = 0; j < 8; j = j + 1) begin
                @(posedge clk_sys_i);
                irq_level_i <= j[2:0];
                @(negedge clk_sys_i);
                chk("irq", j == 7 || j > i[2:0], irq_take_o);
            end
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        bus(4'h0, 1'b0, 32'h0);
        chk("reset", 32'h2700, rd);
        $display("reset test done");
        t_ctrl;
        $display("control test done");
        op(32'h80000000, 32'h80000000, 3'h1, 8'h17);
        op(32'hffffffff, 32'hffffffff, 3'h7, 8'h18);
        op(32'h7fffffff, 32'h1, 3'h1, 8'h0a);
        op(32'h5, 32'h5, 3'h2, 8'h04);
        op(32'hc0000000, 32'h0, 3'h3, 8'h19);
        op(32'h1, 32'h0, 3'h4, 8'h15);
        op(32'h0, 32'h0, 3'h5, 8'h00);
        op(32'h1, 32'h0, 3'h6, 8'h15);
        bus(4'h4, 1'b0, 32'h0);
        chk("result", 32'h0, rd);
        $display("flag test done");
        bus(4'h0, 1'b1, 32'h0);
        bus(4'h0, 1'b1, 32'hffff);
        chk("priv", 32'h0, supervisor_o);
        bus(4'h0, 1'b0, 32'h0);
        chk("user", 32'h1f, rd);
        bus(4'h1, 1'b0, 32'h0);
        chk("err", 32'h1, er);
        $display("user test done");
        give_verdict;
    end
endmodule // tb
